// *** pcc_pkg.sv ***
`default_nettype none
package pcc_pkg;

  // ----------------------------------------------------------------
  // Register map, fieldbus word addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_RUN_CONTROL     = 16'h0b1a;
  localparam logic [15:0] OFS_CRITERION       = 16'h0b1e;
  localparam logic [15:0] OFS_POSITION_SOURCE = 16'h0b22;
  localparam logic [15:0] OFS_VALUE_FIRST     = 16'h0b28;
  localparam logic [15:0] OFS_VALUE_SECOND    = 16'h0b2a;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_RUN_CONTROL     = 16'h0000;
  localparam logic [15:0] RST_CRITERION       = 16'h0000;
  localparam logic [15:0] RST_POSITION_SOURCE = 16'h0000;
  localparam logic [31:0] RST_VALUE           = 32'h0000_0000;
  localparam logic [15:0] MAX_RUN_CONTROL     = 16'h0003;
  localparam logic [15:0] MAX_CRITERION       = 16'h0005;
  localparam logic [15:0] MAX_POSITION_SOURCE = 16'h0000;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CRIT_GE_A      = 3'h0;
  localparam logic [2:0] CRIT_LE_A      = 3'h1;
  localparam logic [2:0] CRIT_IN_BASIC  = 3'h2;
  localparam logic [2:0] CRIT_OUT_BASIC = 3'h3;
  localparam logic [2:0] CRIT_IN_EXT    = 3'h4;
  localparam logic [2:0] CRIT_OUT_EXT   = 3'h5;

  localparam logic [1:0] RUN_OFF_KEEP = 2'h0;
  localparam logic [1:0] RUN_ON       = 2'h1;
  localparam logic [1:0] RUN_OFF_LOW  = 2'h2;
  localparam logic [1:0] RUN_OFF_HIGH = 2'h3;

  // ----------------------------------------------------------------
  // Access carriers
  // ----------------------------------------------------------------
  // Parameter access request from the fieldbus side
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } pcc_req_t;

  // Answer to a parameter access
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } pcc_rsp_t;

endpackage

`default_nettype wire

// *** pcc_compare.sv ***
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Combinational criterion evaluation
// ------------------------------------------------------------------
module pcc_compare (
  input  wire logic        [2:0]  criterion,
  input  wire logic signed [31:0] position,
  input  wire logic signed [31:0] value_a,
  input  wire logic signed [31:0] value_b,
  output logic                    hit
);

  // Window bounds sorted so A above B still forms a span
  wire logic signed [31:0] lo_w   = (value_a < value_b) ? value_a : value_b;
  wire logic signed [31:0] hi_w   = (value_a < value_b) ? value_b : value_a;
  wire logic               ge_a_w = (position >= value_a);
  wire logic               le_a_w = (position <= value_a);
  wire logic               in_w   = (position >= lo_w) && (position <= hi_w);
  wire logic               out_w  = (position < lo_w) || (position > hi_w);

  // Criterion selection; unknown codes never match
  always_comb begin
    case (criterion)
      pcc_pkg::CRIT_GE_A:      hit = ge_a_w;
      pcc_pkg::CRIT_LE_A:      hit = le_a_w;
      pcc_pkg::CRIT_IN_BASIC:  hit = in_w;
      pcc_pkg::CRIT_OUT_BASIC: hit = out_w;
      pcc_pkg::CRIT_IN_EXT:    hit = in_w;
      pcc_pkg::CRIT_OUT_EXT:   hit = out_w;
      default:                 hit = 1'h0;
    endcase
  end

endmodule // pcc_compare

`default_nettype wire

// *** pcc_channel.sv ***
`timescale 1ns/10ps
`default_nettype none

module pcc_channel (
  input  wire logic               MCLK,
  input  wire logic               RST_N,
  input  wire pcc_pkg::pcc_req_t  REQ,
  output pcc_pkg::pcc_rsp_t       RSP,
  input  wire logic signed [31:0] POSITION_ENC1,
  output logic                    STATUS,
  output logic                    RUNNING
);

  // ----------------------------------------------------------------
  // Parameter storage
  // ----------------------------------------------------------------
  // Stored settings and their next values
  logic        [1:0]  run_q;
  logic        [1:0]  run_d;
  logic        [2:0]  crit_q;
  logic        [2:0]  crit_d;
  logic               src_q;
  logic               src_d;
  logic signed [31:0] val_a_q;
  logic signed [31:0] val_a_d;
  logic signed [31:0] val_b_q;
  logic signed [31:0] val_b_d;

  // Status bit and access answer
  logic               status_q;
  logic               status_d;
  pcc_pkg::pcc_rsp_t  rsp_q;
  pcc_pkg::pcc_rsp_t  rsp_d;

  // Live comparator result
  logic               hit;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic sel_run_w  = (REQ.addr == pcc_pkg::OFS_RUN_CONTROL);
  wire logic sel_crit_w = (REQ.addr == pcc_pkg::OFS_CRITERION);
  wire logic sel_src_w  = (REQ.addr == pcc_pkg::OFS_POSITION_SOURCE);
  wire logic sel_a_w    = (REQ.addr == pcc_pkg::OFS_VALUE_FIRST);
  wire logic sel_b_w    = (REQ.addr == pcc_pkg::OFS_VALUE_SECOND);
  wire logic hit_map_w  = sel_run_w | sel_crit_w | sel_src_w | sel_a_w | sel_b_w;

  // ----------------------------------------------------------------
  // Range checks
  // ----------------------------------------------------------------
  // A 16-bit setting with upper bits set is refused, not cut, so
  // the host learns of its mistake from the error flag
  wire logic small_w    = (REQ.wdata[31:16] == 16'h0000);
  wire logic run_ok_w   = small_w && (REQ.wdata[15:0] <= pcc_pkg::MAX_RUN_CONTROL);
  wire logic crit_ok_w  = small_w && (REQ.wdata[15:0] <= pcc_pkg::MAX_CRITERION);
  wire logic src_ok_w   = small_w && (REQ.wdata[15:0] <= pcc_pkg::MAX_POSITION_SOURCE);
  wire logic val_ok_w   = (sel_run_w & run_ok_w) | (sel_crit_w & crit_ok_w)
                        | (sel_src_w & src_ok_w) | sel_a_w | sel_b_w;
  wire logic wr_ok_w    = REQ.wr & val_ok_w;

  // Per-register write enables; a refused value stores nothing.
  // Addresses are exclusive, so at most one enable is high.
  wire logic wr_run_w   = wr_ok_w & sel_run_w;
  wire logic wr_crit_w  = wr_ok_w & sel_crit_w;
  wire logic wr_src_w   = wr_ok_w & sel_src_w;
  wire logic wr_a_w     = wr_ok_w & sel_a_w;
  wire logic wr_b_w     = wr_ok_w & sel_b_w;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read mux; small registers zero-extended
  wire logic [31:0] rd_mux_w =
      sel_run_w  ? {30'h0, run_q}  :
      sel_crit_w ? {29'h0, crit_q} :
      sel_src_w  ? {31'h0, src_q}  :
      sel_a_w    ? val_a_q         :
      sel_b_w    ? val_b_q         : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Parameter writes
  // ----------------------------------------------------------------
  // Retention across power cycles lives in the fieldbus storage,
  // not here; reset loads factory values for every field.
  // A refused write leaves the old setting in place, so a bad
  // host value can never reach the comparator.
  assign run_d   = wr_run_w  ? REQ.wdata[1:0] : run_q;
  assign crit_d  = wr_crit_w ? REQ.wdata[2:0] : crit_q;
  assign src_d   = wr_src_w  ? REQ.wdata[0]   : src_q;
  assign val_a_d = wr_a_w    ? REQ.wdata      : val_a_q;
  assign val_b_d = wr_b_w    ? REQ.wdata      : val_b_q;

  // ----------------------------------------------------------------
  // Setting registers
  // ----------------------------------------------------------------
  // Run code is not kept across power cycles
  // Run control resets off
  always_ff @(posedge MCLK) begin
    if (!RST_N) run_q <= pcc_pkg::RST_RUN_CONTROL[1:0];
    else        run_q <= run_d;
  end

  // Criterion, factory value after reset; only codes 0 to 5 stored
  always_ff @(posedge MCLK) begin
    if (!RST_N) crit_q <= pcc_pkg::RST_CRITERION[2:0];
    else        crit_q <= crit_d;
  end

  // Source is read back only; one source exists
  // Source register, encoder 1 only
  always_ff @(posedge MCLK) begin
    if (!RST_N) src_q <= pcc_pkg::RST_POSITION_SOURCE[0];
    else        src_q <= src_d;
  end

  // Threshold or first window bound
  // Value A default zero
  always_ff @(posedge MCLK) begin
    if (!RST_N) val_a_q <= pcc_pkg::RST_VALUE;
    else        val_a_q <= val_a_d;
  end

  // Second window bound
  // Value B default zero
  always_ff @(posedge MCLK) begin
    if (!RST_N) val_b_q <= pcc_pkg::RST_VALUE;
    else        val_b_q <= val_b_d;
  end

  // ----------------------------------------------------------------
  // Access answer, one cycle after the request
  // ----------------------------------------------------------------
  // Which strobe counts; a write wins when both are raised
  wire logic any_w     = REQ.wr | REQ.rd;
  wire logic rd_only_w = REQ.rd & ~REQ.wr;
  // Refusal: unmapped address, or a value out of range
  wire logic wr_err_w  = REQ.wr & ~(hit_map_w & val_ok_w);
  wire logic rd_err_w  = rd_only_w & ~hit_map_w;

  // Answer word; data only on a read, so errors carry zero
  assign rsp_d = '{ack:   any_w,
                   err:   wr_err_w | rd_err_w,
                   rdata: rd_only_w ? rd_mux_w : 32'h0000_0000};

  // Registered answer: ack never depends on the strobe in the same
  // cycle, so a host must not expect a zero-wait reply
  always_ff @(posedge MCLK) begin
    if (!RST_N) rsp_q <= '0;
    else        rsp_q <= rsp_d;
  end

  // ----------------------------------------------------------------
  // Comparator
  // ----------------------------------------------------------------
  // Bounds are sorted inside, so A may be written above B
  // Encoder 1 is the only source
  pcc_compare u_compare (
    .criterion (crit_q),
    .position  (POSITION_ENC1),
    .value_a   (val_a_q),
    .value_b   (val_b_q),
    .hit       (hit)
  );

  // ----------------------------------------------------------------
  // Status bit
  // ----------------------------------------------------------------
  // Registered so the status pin never glitches while settings
  // change; the price is one cycle from position to status.
  // Uses live settings every cycle
  always_comb begin
    case (run_q)
      pcc_pkg::RUN_ON:       status_d = hit;
      pcc_pkg::RUN_OFF_KEEP: status_d = status_q;
      pcc_pkg::RUN_OFF_LOW:  status_d = 1'h0;
      pcc_pkg::RUN_OFF_HIGH: status_d = 1'h1;
      default:               status_d = status_q;
    endcase
  end

  // Status clears at reset whatever the run code was
  always_ff @(posedge MCLK) begin
    if (!RST_N) status_q <= 1'h0;
    else        status_q <= status_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Status and answer come straight from flip-flops; running is a
  // decode of the stored run code and moves on the taking edge
  assign STATUS  = status_q;
  assign RUNNING = (run_q == pcc_pkg::RUN_ON);
  assign RSP     = rsp_q;

endmodule // pcc_channel

`default_nettype wire

// *** pcc_channel_props.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module pcc_channel_props (
  input wire logic               MCLK,
  input wire logic               RST_N,
  input wire pcc_pkg::pcc_req_t  REQ,
  input wire pcc_pkg::pcc_rsp_t  RSP,
  input wire logic signed [31:0] POSITION_ENC1,
  input wire logic               STATUS,
  input wire logic               RUNNING
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Any-request strobe and decoded write targets
  wire req_any = REQ.wr || REQ.rd;
  wire wr_run  = REQ.wr && REQ.addr == pcc_pkg::OFS_RUN_CONTROL;
  wire wr_crit = REQ.wr && REQ.addr == pcc_pkg::OFS_CRITERION;
  wire wr_src  = REQ.wr && REQ.addr == pcc_pkg::OFS_POSITION_SOURCE;
  a_ack_follows: assert property (req_any |=> RSP.ack)
    else $error("ack missing");
  a_ack_cause: assert property (RSP.ack |-> $past(req_any))
    else $error("ack without request");
  a_err_no_data: assert property (RSP.err |-> RSP.rdata == 32'h0)
    else $error("data on error");
  a_crit_refused: assert property (wr_crit && REQ.wdata > 32'h5 |=> RSP.err)
    else $error("bad criterion taken");
  a_src_refused: assert property (wr_src && REQ.wdata != 32'h0 |=> RSP.err)
    else $error("bad source taken");
  a_run_on: assert property (wr_run && REQ.wdata == 32'h1 |=> RUNNING)
    else $error("not running");
  a_run_keep: assert property (wr_run && REQ.wdata == 32'h0 |=> ##1 $stable(STATUS))
    else $error("status moved while off");
  a_run_low: assert property (wr_run && REQ.wdata == 32'h2 |=> ##1 !STATUS)
    else $error("status not forced low");
  a_run_high: assert property (wr_run && REQ.wdata == 32'h3 |=> ##1 STATUS)
    else $error("status not forced high");
  // Main scenarios reached
  c_err: cover property (RSP.err);
  c_hit: cover property (RUNNING && $rose(STATUS));
  c_stop: cover property (RUNNING ##1 !RUNNING);
endmodule // pcc_channel_props
bind pcc_channel pcc_channel_props u_props (.MCLK(MCLK), .RST_N(RST_N), .REQ(REQ), .RSP(RSP),
  .POSITION_ENC1(POSITION_ENC1), .STATUS(STATUS), .RUNNING(RUNNING));
`default_nettype wire

// *** position_compare_channel_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module position_compare_channel_bench;
  typedef struct packed {logic [2:0] c; logic [1:0] i; logic e;} pcc_row_t;
  logic               MCLK;
  logic               RST_N;
  logic               STATUS;
  logic               RUNNING;
  logic signed [31:0] POSITION_ENC1;
  pcc_pkg::pcc_req_t  REQ;
  pcc_pkg::pcc_rsp_t  RSP;
  int                 fail_count = 0;
  int                 samples_checked = 0;
  int                 cycles = 0;
  // Probe points A-1, A, B, B+1 with A = -10, B = 20
  logic [31:0] pos_tab [4] = '{32'hffff_fff5, 32'hffff_fff6, 32'h0000_0014, 32'h0000_0015};
  logic [15:0] regs [5] = '{pcc_pkg::OFS_RUN_CONTROL, pcc_pkg::OFS_CRITERION,
    pcc_pkg::OFS_POSITION_SOURCE, pcc_pkg::OFS_VALUE_FIRST, pcc_pkg::OFS_VALUE_SECOND};
  // Criterion, probe point, expected status
  pcc_row_t rows [12] = '{'{3'h0, 2'h0, 1'h0}, '{3'h0, 2'h1, 1'h1}, '{3'h1, 2'h1, 1'h1},
    '{3'h1, 2'h2, 1'h0}, '{3'h2, 2'h2, 1'h1}, '{3'h2, 2'h3, 1'h0}, '{3'h3, 2'h2, 1'h0},
    '{3'h3, 2'h0, 1'h1}, '{3'h4, 2'h1, 1'h1}, '{3'h4, 2'h0, 1'h0}, '{3'h5, 2'h3, 1'h1},
    '{3'h5, 2'h1, 1'h0}};

  pcc_channel uut (.MCLK(MCLK), .RST_N(RST_N), .REQ(REQ), .RSP(RSP),
    .POSITION_ENC1(POSITION_ENC1), .STATUS(STATUS), .RUNNING(RUNNING));

  // Clock and hang limit; the run needs under a hundred cycles
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // One access; strobe dropped and an edge let pass before the next
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] rd);
    REQ = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge MCLK);
    REQ = '0;
    chk("ack", RSP.ack, 32'h1);
    chk("err", RSP.err, err);
    chk("rdata", RSP.rdata, rd);
    @(negedge MCLK);
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    RST_N = 1'b0;
    REQ = '0;
    POSITION_ENC1 = 32'sh0;
    repeat (6) @(negedge MCLK);
    RST_N = 1'b1;
    chk("status", STATUS, 32'h0);
    chk("running", RUNNING, 32'h0);
    foreach (regs[k]) acc(1'b0, regs[k], 32'h0, 1'b0, 32'h0);
    acc(1'b0, 16'h0b1c, 32'h0, 1'b1, 32'h0);
    acc(1'b1, pcc_pkg::OFS_VALUE_FIRST, pos_tab[1], 1'b0, 32'h0);
    acc(1'b1, pcc_pkg::OFS_VALUE_SECOND, pos_tab[2], 1'b0, 32'h0);
    acc(1'b0, pcc_pkg::OFS_VALUE_FIRST, 32'h0, 1'b0, pos_tab[1]);
    acc(1'b1, pcc_pkg::OFS_RUN_CONTROL, 32'h1, 1'b0, 32'h0);
    chk("running", RUNNING, 32'h1);
    foreach (rows[k]) begin
      POSITION_ENC1 = pos_tab[rows[k].i];
      acc(1'b1, pcc_pkg::OFS_CRITERION, {29'h0, rows[k].c}, 1'b0, 32'h0);
      chk("status", STATUS, rows[k].e);
    end
    POSITION_ENC1 = pos_tab[3];
    @(negedge MCLK);
    chk("status", STATUS, 32'h1);
    acc(1'b1, pcc_pkg::OFS_RUN_CONTROL, 32'h0, 1'b0, 32'h0);
    POSITION_ENC1 = pos_tab[1];
    @(negedge MCLK);
    chk("status", STATUS, 32'h1);
    chk("running", RUNNING, 32'h0);
    acc(1'b1, pcc_pkg::OFS_RUN_CONTROL, 32'h2, 1'b0, 32'h0);
    chk("status", STATUS, 32'h0);
    acc(1'b1, pcc_pkg::OFS_RUN_CONTROL, 32'h3, 1'b0, 32'h0);
    chk("status", STATUS, 32'h1);
    acc(1'b1, pcc_pkg::OFS_CRITERION, 32'h6, 1'b1, 32'h0);
    acc(1'b1, pcc_pkg::OFS_RUN_CONTROL, 32'h4, 1'b1, 32'h0);
    acc(1'b1, pcc_pkg::OFS_RUN_CONTROL, 32'h0001_0001, 1'b1, 32'h0);
    acc(1'b1, pcc_pkg::OFS_POSITION_SOURCE, 32'h1, 1'b1, 32'h0);
    acc(1'b1, pcc_pkg::OFS_POSITION_SOURCE, 32'h0, 1'b0, 32'h0);
    acc(1'b0, pcc_pkg::OFS_CRITERION, 32'h0, 1'b0, 32'h5);
    acc(1'b0, pcc_pkg::OFS_RUN_CONTROL, 32'h0, 1'b0, 32'h3);
    // Back to back: write A, read it in the very next cycle
    REQ = '{wr: 1'b1, rd: 1'b0, addr: pcc_pkg::OFS_VALUE_FIRST, wdata: 32'h0000_0007};
    @(negedge MCLK);
    REQ = '{wr: 1'b0, rd: 1'b1, addr: pcc_pkg::OFS_VALUE_FIRST, wdata: 32'h0};
    chk("ack", RSP.ack, 32'h1);
    chk("err", RSP.err, 32'h0);
    @(negedge MCLK);
    REQ = '0;
    chk("ack", RSP.ack, 32'h1);
    chk("rdata", RSP.rdata, 32'h0000_0007);
    @(negedge MCLK);
    // Running with status high, so the reset below has work to do
    POSITION_ENC1 = pos_tab[3];
    acc(1'b1, pcc_pkg::OFS_RUN_CONTROL, 32'h1, 1'b0, 32'h0);
    chk("status", STATUS, 32'h1);
    chk("running", RUNNING, 32'h1);
    // Second reset in mid-run
    RST_N = 1'b0;
    repeat (2) @(negedge MCLK);
    RST_N = 1'b1;
    chk("status", STATUS, 32'h0);
    chk("running", RUNNING, 32'h0);
    acc(1'b0, pcc_pkg::OFS_RUN_CONTROL, 32'h0, 1'b0, 32'h0);
    acc(1'b0, pcc_pkg::OFS_VALUE_FIRST, 32'h0, 1'b0, 32'h0);
    summarize();
  end
endmodule // position_compare_channel_bench
`default_nettype wire
